// *** kgd_cfg.svh ***
// Constants for the knock gesture detector: offsets, fields, resets, windows.
// Assumes an APB slave with byte addresses and 32-bit data, one word per register.
`ifndef KGD_CFG_SVH
`define KGD_CFG_SVH

// Register byte offsets
`define KGD_OFF_CTRL      8'h00
`define KGD_OFF_THRESHOLD 8'h04
`define KGD_OFF_TIMING    8'h08
`define KGD_OFF_WAKE      8'h0c
`define KGD_OFF_ROUTE_ONE 8'h10
`define KGD_OFF_ROUTE_TWO 8'h14
`define KGD_OFF_SOURCE    8'h1c

// Control register fields
`define KGD_CTRL_IE       0
`define KGD_CTRL_LIR      1
`define KGD_CTRL_XEN      2
`define KGD_CTRL_ZEN      4
`define KGD_CTRL_MASK     8'h1f

// Threshold and wake register fields
`define KGD_THR_MASK      8'h1f
`define KGD_WAKE_SEL      7
`define KGD_WAKE_MASK     8'hbf

// Routing register fields
`define KGD_ROUTE_SINGLE  0
`define KGD_ROUTE_DOUBLE  1
`define KGD_ROUTE_MASK    8'h03

// Knock source fields
`define KGD_SRC_ANY       6
`define KGD_SRC_SINGLE    5
`define KGD_SRC_DOUBLE    4
`define KGD_SRC_SIGN      3
`define KGD_SRC_X         2

// Reset value of every writable register
`define KGD_RESET_VAL     8'h00

// Window lengths in sample periods
`define KGD_SHOCK_BASE    10'h004
`define KGD_SHOCK_UNIT    10'h008
`define KGD_QUIET_BASE    10'h002
`define KGD_QUIET_UNIT    10'h004
`define KGD_GAP_BASE      10'h010
`define KGD_GAP_UNIT      10'h020

`endif

// *** kgd_pkg.sv ***
// Types shared by the knock gesture detector and its bench.
// Assumes kgd_cfg.svh supplies all numeric constants.
package kgd_pkg;

    // One three-axis sample, two's complement, full scale at 2^15
    typedef struct packed {
        logic signed [15:0] z;
        logic signed [15:0] y;
        logic signed [15:0] x;
    } kgd_axes_t;

    // Detection sequence
    typedef enum logic [2:0] {
        KGD_IDLE,
        KGD_SHOCK_ONE,
        KGD_QUIET,
        KGD_GAP,
        KGD_SHOCK_TWO,
        KGD_RELEASE
    } kgd_fsm_t;

    // Whole state of the detector
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  thr;
        logic [7:0]  timing;
        logic [7:0]  wake;
        logic [7:0]  route_one;
        logic [7:0]  route_two;
        logic [7:0]  src;
        logic [31:0] prdata;
        logic        pslverr;
        kgd_fsm_t    fsm;
        logic [9:0]  cnt;
        kgd_axes_t   prev;
        logic [2:0]  hit_axes;
        logic        hit_sign;
        logic [9:0]  pulse_cnt;
        logic        pulse_single;
        logic        pulse_double;
        logic        latch_single;
        logic        latch_double;
        logic        irq_one;
        logic        irq_two;
    } kgd_state_t;

endpackage

// *** kgd_knock_detector.sv ***
// Single and double knock detector on a three-axis sample stream, APB registers.
// Assumes samples and the inactivity level come from logic on pclk; no sync.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "kgd_cfg.svh"

// Summary of operation
// - Slope is half the sample-to-sample difference
// - Single knock: rise, fall within shock
// - Unlatched interrupt lasts exactly the quiet window
// - Single latched when latch and double route set and select bit zero
// - Second knock starts after quiet, before gap ends
// - Second knock must fall within shock window
// - Latched double held until source read
// - Only enabled axes are evaluated
// - Five-bit threshold against slope magnitude
// - Shock window: 4 or value times 8
// - Quiet window: 2 or value times 4
// - Gap window: 16 or value times 32
// - Per-pin per-event routing bits gate pins
// - Inactivity suppresses all knock interrupts
// - Source sets any, single, double flags
// - Sign flag low positive, high negative
// - Per-axis flag marks knocking axis
// - Select bit zero disables double knocks
// - Latch targets single or double by select
// - Without a double route the latch request is ignored
// - Inactivity means slow internal sample rate
module kgd_knock_detector (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Sample stream, one valid pulse per data period
    input  wire logic               sample_valid,
    input  wire kgd_pkg::kgd_axes_t sample,
    // Level from the activity logic
    input  wire logic               inactive_state,
    // Interrupt pins
    output logic                    irq_pin_one,
    output logic                    irq_pin_two
);

    // Shock window length from its field
    function automatic logic [9:0] shock_len(input logic [1:0] f);
        return (f == 2'h0) ? `KGD_SHOCK_BASE : ({8'h0, f} * `KGD_SHOCK_UNIT);
    endfunction

    // Quiet window length from its field
    function automatic logic [9:0] quiet_len(input logic [1:0] f);
        return (f == 2'h0) ? `KGD_QUIET_BASE : ({8'h0, f} * `KGD_QUIET_UNIT);
    endfunction

    // Gap window length from its field
    function automatic logic [9:0] gap_len(input logic [3:0] f);
        return (f == 4'h0) ? `KGD_GAP_BASE : ({6'h0, f} * `KGD_GAP_UNIT);
    endfunction

    // Register-map decode of an address
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    kgd_pkg::kgd_state_t s_reg;          // Registered state
    kgd_pkg::kgd_state_t s_next;         // Next state

    logic [2:0][15:0]    cur_arr;        // Current sample, axis indexed
    logic [2:0][15:0]    prev_arr;       // Previous sample, axis indexed
    logic [2:0][15:0]    slope_arr;      // Slope per axis
    logic [2:0][15:0]    mag_arr;        // Slope magnitude per axis
    logic [2:0]          above_ax;       // Enabled axes above threshold
    logic [2:0]          axis_en;        // Per-axis enables
    logic [15:0]         thr_level;      // Threshold in sample units
    logic                any_above;      // Any enabled axis above threshold
    logic                first_sign;     // Sign of first axis above
    logic                tick;           // One data period has passed
    logic                ie;             // Global knock enable
    logic                sel_double;     // Double knocks enabled
    logic                latch_on;       // Latch request is in force
    logic                single_evt;     // Single knock recognised
    logic                double_evt;     // Double knock recognised
    logic                apb_setup;      // Setup phase of a transfer
    logic                apb_access;     // Access phase of a transfer
    logic                rd_source;      // Source register being read
    logic                act_single;     // Single interrupt request active
    logic                act_double;     // Double interrupt request active

    // Zero-wait slave
    assign pready  = 1'b1;
    assign prdata  = s_reg.prdata;
    assign pslverr = s_reg.pslverr;

    // Pins come straight from flops
    assign irq_pin_one = s_reg.irq_one;
    assign irq_pin_two = s_reg.irq_two;

    // Field views of the control registers
    assign ie         = s_reg.ctrl[`KGD_CTRL_IE];
    assign axis_en    = s_reg.ctrl[`KGD_CTRL_ZEN:`KGD_CTRL_XEN];
    assign sel_double = s_reg.wake[`KGD_WAKE_SEL];
    assign thr_level  = {1'b0, s_reg.thr[4:0], 10'h000};

    // Latch only when a double route exists on some pin
    assign latch_on = s_reg.ctrl[`KGD_CTRL_LIR]
                      & (s_reg.route_one[`KGD_ROUTE_DOUBLE]
                         | s_reg.route_two[`KGD_ROUTE_DOUBLE]);

    // Axis views of the samples
    assign cur_arr  = {sample.z, sample.y, sample.x};
    assign prev_arr = {s_reg.prev.z, s_reg.prev.y, s_reg.prev.x};

    // Slope and threshold test per axis
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            logic [16:0] diff;
            // Difference at full width, then halved
            assign diff = {cur_arr[gi][15], cur_arr[gi]} - {prev_arr[gi][15], prev_arr[gi]};
            assign slope_arr[gi] = diff[16:1];
            // Magnitude of positive and negative slopes
            assign mag_arr[gi] = slope_arr[gi][15] ? 16'(~slope_arr[gi] + 16'h0001)
                                                   : slope_arr[gi];
            assign above_ax[gi] = axis_en[gi] & (mag_arr[gi] > thr_level);
        end
    endgenerate

    // Detection runs only with the global enable set
    assign any_above = ie & (|above_ax);

    // Sign of the first axis above, x first
    always_comb begin
        if (above_ax[0]) begin
            first_sign = slope_arr[0][15];
        end else if (above_ax[1]) begin
            first_sign = slope_arr[1][15];
        end else begin
            first_sign = slope_arr[2][15];
        end
    end

    // One data period, ignored while the block is disabled
    assign tick = sample_valid & ie;

    // APB phases
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;
    assign rd_source  = apb_access & ~pwrite & addr_is(paddr, `KGD_OFF_SOURCE);

    // Active requests as held in state
    assign act_single = s_reg.pulse_single | s_reg.latch_single;
    assign act_double = s_reg.pulse_double | s_reg.latch_double;

    // Detection sequence
    always_comb begin
        s_next     = s_reg;
        single_evt = 1'b0;
        double_evt = 1'b0;

        // Previous sample follows every valid sample
        if (sample_valid) begin
            s_next.prev = sample;
        end

        if (!ie) begin
            // Disabled: forget any partial knock
            s_next.fsm = kgd_pkg::KGD_IDLE;
            s_next.cnt = 10'h000;
        end else if (tick) begin
            unique case (s_reg.fsm)
                // Wait for a slope above threshold
                kgd_pkg::KGD_IDLE: begin
                    if (any_above) begin
                        s_next.fsm      = kgd_pkg::KGD_SHOCK_ONE;
                        s_next.cnt      = 10'h001;
                        s_next.hit_axes = above_ax;
                        s_next.hit_sign = first_sign;
                    end
                end
                // First knock must fall back inside the shock window
                kgd_pkg::KGD_SHOCK_ONE: begin
                    if (!any_above) begin
                        single_evt = 1'b1;
                        s_next.cnt = 10'h000;
                        // Double detection continues only when selected
                        s_next.fsm = sel_double ? kgd_pkg::KGD_QUIET
                                                : kgd_pkg::KGD_IDLE;
                    end else if (s_reg.cnt >= shock_len(s_reg.timing[1:0])) begin
                        s_next.fsm = kgd_pkg::KGD_RELEASE;
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
                // No slope above threshold allowed here
                kgd_pkg::KGD_QUIET: begin
                    if (any_above) begin
                        s_next.fsm = kgd_pkg::KGD_RELEASE;
                    end else if (s_reg.cnt + 10'h001 >= quiet_len(s_reg.timing[3:2])) begin
                        s_next.fsm = kgd_pkg::KGD_GAP;
                        s_next.cnt = 10'h000;
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
                // Second knock must start before the gap ends
                kgd_pkg::KGD_GAP: begin
                    if (any_above) begin
                        s_next.fsm      = kgd_pkg::KGD_SHOCK_TWO;
                        s_next.cnt      = 10'h001;
                        s_next.hit_axes = above_ax;
                        s_next.hit_sign = first_sign;
                    end else if (s_reg.cnt + 10'h001 >= gap_len(s_reg.timing[7:4])) begin
                        s_next.fsm = kgd_pkg::KGD_IDLE;
                        s_next.cnt = 10'h000;
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
                // Second knock, same shock test as the first
                kgd_pkg::KGD_SHOCK_TWO: begin
                    if (!any_above) begin
                        double_evt = 1'b1;
                        s_next.fsm = kgd_pkg::KGD_IDLE;
                        s_next.cnt = 10'h000;
                    end else if (s_reg.cnt >= shock_len(s_reg.timing[1:0])) begin
                        s_next.fsm = kgd_pkg::KGD_RELEASE;
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
                // Rejected knock: wait for the slope to drop
                kgd_pkg::KGD_RELEASE: begin
                    if (!any_above) begin
                        s_next.fsm = kgd_pkg::KGD_IDLE;
                        s_next.cnt = 10'h000;
                    end
                end
                // Illegal code recovers to idle
                default: begin
                    s_next.fsm = kgd_pkg::KGD_IDLE;
                    s_next.cnt = 10'h000;
                end
            endcase
        end

        // Inactivity drops events before they reach flags or pins
        if (inactive_state) begin
            single_evt = 1'b0;
            double_evt = 1'b0;
        end

        // Pulse countdown in data periods
        if (tick && s_reg.pulse_cnt != 10'h000) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 10'h001;
            if (s_reg.pulse_cnt == 10'h001) begin
                s_next.pulse_single = 1'b0;
                s_next.pulse_double = 1'b0;
            end
        end

        // Reading the source clears latches and flags
        if (rd_source) begin
            s_next.latch_single = 1'b0;
            s_next.latch_double = 1'b0;
            s_next.src          = 8'h00;
        end

        // New events; placed after the clear so that a set wins
        if (single_evt) begin
            s_next.src = 8'h00;
            s_next.src[`KGD_SRC_ANY]    = 1'b1;
            s_next.src[`KGD_SRC_SINGLE] = 1'b1;
            s_next.src[`KGD_SRC_SIGN]   = s_next.hit_sign;
            // Axis flags run X, Y, Z from the top down, so the order flips
            s_next.src[`KGD_SRC_X:0]    = {<<{s_next.hit_axes}};
            if (latch_on && !sel_double) begin
                s_next.latch_single = 1'b1;
            end else begin
                s_next.pulse_single = 1'b1;
                s_next.pulse_double = 1'b0;
                s_next.pulse_cnt    = quiet_len(s_reg.timing[3:2]);
            end
        end
        if (double_evt) begin
            s_next.src = 8'h00;
            s_next.src[`KGD_SRC_ANY]    = 1'b1;
            s_next.src[`KGD_SRC_DOUBLE] = 1'b1;
            s_next.src[`KGD_SRC_SIGN]   = s_next.hit_sign;
            s_next.src[`KGD_SRC_X:0]    = {<<{s_next.hit_axes}};
            if (latch_on && sel_double) begin
                s_next.latch_double = 1'b1;
            end else begin
                s_next.pulse_double = 1'b1;
                s_next.pulse_single = 1'b0;
                s_next.pulse_cnt    = quiet_len(s_reg.timing[3:2]);
            end
        end

        // Pin drive from held requests and routing
        s_next.irq_one = ~inactive_state
                         & ((act_single & s_reg.route_one[`KGD_ROUTE_SINGLE])
                            | (act_double & s_reg.route_one[`KGD_ROUTE_DOUBLE]));
        s_next.irq_two = ~inactive_state
                         & ((act_single & s_reg.route_two[`KGD_ROUTE_SINGLE])
                            | (act_double & s_reg.route_two[`KGD_ROUTE_DOUBLE]));

        // Register writes take effect in the access phase
        if (apb_access && pwrite) begin
            if (addr_is(paddr, `KGD_OFF_CTRL)) begin
                s_next.ctrl = pwdata[7:0] & `KGD_CTRL_MASK;
            end else if (addr_is(paddr, `KGD_OFF_THRESHOLD)) begin
                s_next.thr = pwdata[7:0] & `KGD_THR_MASK;
            end else if (addr_is(paddr, `KGD_OFF_TIMING)) begin
                s_next.timing = pwdata[7:0];
            end else if (addr_is(paddr, `KGD_OFF_WAKE)) begin
                s_next.wake = pwdata[7:0] & `KGD_WAKE_MASK;
            end else if (addr_is(paddr, `KGD_OFF_ROUTE_ONE)) begin
                s_next.route_one = pwdata[7:0] & `KGD_ROUTE_MASK;
            end else if (addr_is(paddr, `KGD_OFF_ROUTE_TWO)) begin
                s_next.route_two = pwdata[7:0] & `KGD_ROUTE_MASK;
            end
        end

        // Read data and error prepared in the setup phase
        if (apb_setup) begin
            s_next.pslverr = 1'b0;
            s_next.prdata  = 32'h0000_0000;
            if (addr_is(paddr, `KGD_OFF_CTRL)) begin
                s_next.prdata[7:0] = s_reg.ctrl;
            end else if (addr_is(paddr, `KGD_OFF_THRESHOLD)) begin
                s_next.prdata[7:0] = s_reg.thr;
            end else if (addr_is(paddr, `KGD_OFF_TIMING)) begin
                s_next.prdata[7:0] = s_reg.timing;
            end else if (addr_is(paddr, `KGD_OFF_WAKE)) begin
                s_next.prdata[7:0] = s_reg.wake;
            end else if (addr_is(paddr, `KGD_OFF_ROUTE_ONE)) begin
                s_next.prdata[7:0] = s_reg.route_one;
            end else if (addr_is(paddr, `KGD_OFF_ROUTE_TWO)) begin
                s_next.prdata[7:0] = s_reg.route_two;
            end else if (addr_is(paddr, `KGD_OFF_SOURCE)) begin
                // Source is read-only; a write there is a slave error
                s_next.prdata[7:0] = s_reg.src;
                s_next.pslverr     = pwrite;
            end else begin
                // Unmapped address
                s_next.pslverr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{ctrl:      `KGD_RESET_VAL,
                       thr:       `KGD_RESET_VAL,
                       timing:    `KGD_RESET_VAL,
                       wake:      `KGD_RESET_VAL,
                       route_one: `KGD_RESET_VAL,
                       route_two: `KGD_RESET_VAL,
                       fsm:       kgd_pkg::KGD_IDLE,
                       default:   '0};
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// *** kgd_knock_detector_asserts.sv ***
// Port checker for the knock detector.
// Assumes it is bound onto kgd_knock_detector.
`timescale 1ns/1ps
`default_nettype none
module kgd_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Stream and pins
    input wire logic        sample_valid,
    input wire logic        inactive_state,
    input wire logic        irq_pin_one,
    input wire logic        irq_pin_two
);
    logic acc;   // Access phase
    logic cause; // Tick, access or inactivity
    assign acc = psel && penable;
    // A pin may rise only two cycles after a cause; it may also fall one cycle after inactivity
    assign cause = sample_valid | acc | inactive_state;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_now_a: assert property (acc |-> pready) else $error("no ready");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    src_ro_a: assert property (acc && pwrite && paddr == 8'h1c |-> pslverr)
        else $error("source write accepted");
    unmapped_a: assert property (acc && (paddr == 8'h18 || paddr > 8'h1c)
        |-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
    inact_quiet_a: assert property (inactive_state [*3]
        |-> !irq_pin_one && !irq_pin_two) else $error("pin during inactivity");
    one_rise_a: assert property ($rose(irq_pin_one) |-> $past(cause, 2))
        else $error("pin one rose uncaused");
    two_rise_a: assert property ($rose(irq_pin_two) |-> $past(cause, 2))
        else $error("pin two rose uncaused");
    one_fall_a: assert property ($fell(irq_pin_one)
        |-> $past(cause, 2) || $past(inactive_state)) else $error("pin one fell uncaused");
    two_fall_a: assert property ($fell(irq_pin_two)
        |-> $past(cause, 2) || $past(inactive_state)) else $error("pin two fell uncaused");
    one_c: cover property ($rose(irq_pin_one));
    two_c: cover property ($rose(irq_pin_two));
    rd_c: cover property (acc && !pwrite && paddr == 8'h1c);
endmodule
bind kgd_knock_detector kgd_chk u_kgd_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .inactive_state(inactive_state),
    .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
`default_nettype wire

// *** kgd_sample_src.sv ***
// Sample source standing in for the sensing front end.
// Assumes the bench sets the next value between ticks.
`timescale 1ns/1ps
`default_nettype none
module kgd_sample_src (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Value for the next tick
    input  wire kgd_pkg::kgd_axes_t next_val,
    // Stream to the detector
    output logic                    sample_valid,
    output kgd_pkg::kgd_axes_t      sample
);
    logic [1:0] cnt_reg; // Position in the data period
    // Steady tick every four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg      <= 2'h0;
            sample_valid <= 1'b0;
        end else begin
            cnt_reg      <= cnt_reg + 2'h1;
            sample_valid <= (cnt_reg == 2'h3);
        end
    end
    // Garbage between ticks so stale data is never trusted
    assign sample = sample_valid ? next_val : ~next_val;
endmodule
`default_nettype wire

// *** kgd_knock_detector_tb.sv ***
// Bench for the knock detector: registers, knocks, refusals.
// Assumes the sample source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "kgd_cfg.svh"
module kgd_knock_detector_tb;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               sample_valid;
    kgd_pkg::kgd_axes_t sample;
    kgd_pkg::kgd_axes_t nv = '0;
    logic               inactive_state = 1'b0;
    logic               irq_pin_one;
    logic               irq_pin_two;
    logic [31:0]        rd;
    logic               er;
    int                 fails = 0;
    int                 tests_run = 0;
    int                 cycles = 0;
    always #12.5 pclk = ~pclk;
    kgd_knock_detector u_kgd_knock_detector (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample(sample),
        .inactive_state(inactive_state), .irq_pin_one(irq_pin_one),
        .irq_pin_two(irq_pin_two));
    kgd_sample_src u_kgd_sample_src (.pclk(pclk), .presetn(presetn),
        .next_val(nv), .sample_valid(sample_valid), .sample(sample));
    // One APB transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // Present a value and wait for the tick that takes it
    task automatic step(input kgd_pkg::kgd_axes_t v);
        @(posedge pclk);
        nv <= v;
        do @(negedge pclk); while (sample_valid !== 1'b1);
        @(posedge pclk);
    endtask
    // Jump above threshold, then hold still for a zero slope
    task automatic knock(input logic signed [15:0] dx, input logic signed [15:0] dy);
        kgd_pkg::kgd_axes_t v;
        v = nv;
        v.x = v.x + dx;
        v.y = v.y + dy;
        step(v);
        step(v);
        repeat (3) @(negedge pclk);
    endtask
    task automatic cfg(input logic [7:0] c, input logic [7:0] w, input logic [7:0] r1,
                       input logic [7:0] r2);
        apb(1'b1, `KGD_OFF_CTRL, {24'h0, c});
        apb(1'b1, `KGD_OFF_WAKE, {24'h0, w});
        apb(1'b1, `KGD_OFF_ROUTE_ONE, {24'h0, r1});
        apb(1'b1, `KGD_OFF_ROUTE_TWO, {24'h0, r2});
    endtask
    task automatic src(input string n, input logic [31:0] e);
        apb(1'b0, `KGD_OFF_SOURCE, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `KGD_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, `KGD_OFF_SOURCE, 32'hff);
        chk("source ro err", 32'h1, {31'h0, er});
        apb(1'b1, `KGD_OFF_THRESHOLD, 32'h1);
        apb(1'b1, `KGD_OFF_TIMING, 32'h0);
        // Single knock, latch asked but no double route: plain pulse
        cfg(8'h1f, 8'h00, 8'h01, 8'h00);
        knock(16'sd4000, 16'sd0);
        chk("pin one up", 32'h1, {31'h0, irq_pin_one});
        chk("pin two off", 32'h0, {31'h0, irq_pin_two});
        step(nv);
        @(negedge pclk);
        chk("pin one held", 32'h1, {31'h0, irq_pin_one});
        step(nv);
        repeat (3) @(negedge pclk);
        chk("pin one down", 32'h0, {31'h0, irq_pin_one});
        src("single src", 32'h64);
        src("src cleared", 32'h0);
        // Negative knock on Y
        knock(16'sd0, -16'sd4000);
        src("sign src", 32'h6a);
        // Ramp: four ticks above still pass, six are rejected
        repeat (4) step('{z: nv.z, y: nv.y, x: nv.x + 16'sd2500});
        step(nv);
        src("shock edge", 32'h64);
        repeat (6) step('{z: nv.z, y: nv.y, x: nv.x - 16'sd2500});
        step(nv);
        src("shock reject", 32'h0);
        // Double knock latched on pin two
        cfg(8'h1f, 8'h80, 8'h00, 8'h02);
        knock(-16'sd4000, 16'sd0);
        repeat (3) step(nv);
        knock(-16'sd4000, 16'sd0);
        repeat (4) step(nv);
        chk("double latched", 32'h1, {31'h0, irq_pin_two});
        src("double src", 32'h5c);
        repeat (3) @(negedge pclk);
        chk("latch cleared", 32'h0, {31'h0, irq_pin_two});
        // Inactivity, disabled axis, global enable off
        cfg(8'h1d, 8'h00, 8'h01, 8'h01);
        inactive_state <= 1'b1;
        knock(16'sd4000, 16'sd0);
        chk("inactive pins", 32'h0, {30'h0, irq_pin_one, irq_pin_two});
        src("inactive src", 32'h0);
        inactive_state <= 1'b0;
        cfg(8'h19, 8'h00, 8'h01, 8'h00);
        knock(16'sd4000, 16'sd0);
        src("x disabled", 32'h0);
        cfg(8'h1c, 8'h00, 8'h01, 8'h00);
        knock(16'sd4000, 16'sd0);
        src("enable off", 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
